/* pcrb_regs.svh */
// register offsets, reset values and field positions of the port and cell register bank
// assumes: offsets are relative to the 256-byte window picked by the host decoder
`ifndef PCRB_REGS_SVH
`define PCRB_REGS_SVH
// pin level readback, per port A..G
`define PCRB_DIN_A 8'h00
`define PCRB_DIN_B 8'h01
`define PCRB_DIN_C 8'h10
`define PCRB_DIN_D 8'h11
`define PCRB_DIN_E 8'h30
`define PCRB_DIN_F 8'h40
`define PCRB_DIN_G 8'h41
// output latches
`define PCRB_DOUT_A 8'h04
`define PCRB_DOUT_B 8'h05
`define PCRB_DOUT_C 8'h12
`define PCRB_DOUT_D 8'h13
`define PCRB_DOUT_E 8'h34
`define PCRB_DOUT_F 8'h44
`define PCRB_DOUT_G 8'h45
// pin direction
`define PCRB_DIR_A 8'h06
`define PCRB_DIR_B 8'h07
`define PCRB_DIR_C 8'h14
`define PCRB_DIR_D 8'h15
`define PCRB_DIR_E 8'h36
`define PCRB_DIR_F 8'h46
`define PCRB_DIR_G 8'h47
// driver select (open drain or slew)
`define PCRB_DRV_A 8'h08
`define PCRB_DRV_B 8'h09
`define PCRB_DRV_C 8'h18
`define PCRB_DRV_D 8'h19
`define PCRB_DRV_E 8'h38
`define PCRB_DRV_F 8'h48
`define PCRB_DRV_G 8'h49
// function select, ports E F G
`define PCRB_CTL_E 8'h32
`define PCRB_CTL_F 8'h42
`define PCRB_CTL_G 8'h43
// driver enable status, ports A B C F
`define PCRB_OES_A 8'h0c
`define PCRB_OES_B 8'h0d
`define PCRB_OES_C 8'h1c
`define PCRB_OES_F 8'h4c
// input cells, groups on ports A B C
`define PCRB_ICL_A 8'h0a
`define PCRB_ICL_B 8'h0b
`define PCRB_ICL_C 8'h1a
// output cells and their write masks
`define PCRB_OCELL_A 8'h20
`define PCRB_OCELL_B 8'h21
`define PCRB_MASK_A 8'h22
`define PCRB_MASK_B 8'h23
// protection, debug port and page
`define PCRB_PROT_PRI 8'hc0
`define PCRB_PROT_SEC 8'hc2
`define PCRB_DBG_EN 8'hc7
`define PCRB_PAGE 8'he0
// fields and reset values
`define PCRB_SEC_SECURITY_BIT 7
`define PCRB_DBG_ON_BIT 0
`define PCRB_RST_BYTE 8'h00
`endif

/* pcrb_pkg.sv */
// types shared by the port and cell register bank
// assumes: included after pcrb_regs.svh where offsets are needed
package pcrb_pkg;
    typedef logic [7:0] pcrb_byte_t;
    // port numbering used for every per-port array
    typedef enum {PCRB_PA, PCRB_PB, PCRB_PC, PCRB_PD, PCRB_PE, PCRB_PF, PCRB_PG} pcrb_port_t;
    typedef logic [6:0][7:0] pcrb_ports_t;
endpackage

/* pcrb_port.sv */
// one eight-pin port: input synchroniser and output driver control
// assumes: the pad ring resolves pin_out and pin_oe into the real wire
`include "pcrb_regs.svh"
module pcrb_port #(
    parameter bit OD_CAPABLE = 1'b1,
    parameter bit SLEW_CAPABLE = 1'b0,
    parameter bit ADDR_CAPABLE = 1'b0
) (
    input wire logic clk, // bank clock
    input wire logic rst_b, // async reset, active low
    input wire logic [7:0] pin_in, // raw pad levels
    input wire logic [7:0] out_latch, // host output latch
    input wire logic [7:0] direction, // 1 = output
    input wire logic [7:0] drive_sel, // open drain or slew select
    input wire logic [7:0] func_sel, // 1 = latched address out
    input wire logic [7:0] latched_addr, // latched bus address
    output logic [7:0] pin_level, // synchronised pad level
    output logic [7:0] pin_out, // pad output value
    output logic [7:0] pin_oe, // pad output enable
    output logic [7:0] slew_fast // fast slew request
);
    logic [7:0] meta_q;
    logic [7:0] addr_mode;
    logic [7:0] val;
    logic [7:0] od;

    // -----------------------------------------------------------
    // input synchroniser
    // -----------------------------------------------------------
    // pads are asynchronous, so two flops before anyone reads them
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= `PCRB_RST_BYTE;
            pin_level <= `PCRB_RST_BYTE;
        end
        else
        begin
            meta_q <= pin_in;
            pin_level <= meta_q; // R1
        end
    end

    // -----------------------------------------------------------
    // driver control
    // -----------------------------------------------------------
    // address mode overrides the direction bit and drives, except where open drain releases a one
    assign addr_mode = ADDR_CAPABLE ? func_sel : 8'h00; // R4
    assign val = (addr_mode & latched_addr) | (~addr_mode & out_latch); // R2 R4
    assign od = OD_CAPABLE ? drive_sel : 8'h00; // R5
    // open drain pulls low only, so a one releases the pad
    assign pin_out = val & ~od; // R5
    assign pin_oe = (direction | addr_mode) & (~od | ~val); // R3 R5
    assign slew_fast = SLEW_CAPABLE ? drive_sel : 8'h00; // R6
endmodule // pcrb_port

/* pcrb_top.sv */
// port and cell register bank: byte registers in a 256-byte host window
// assumes: host strobes are one clk cycle wide and synchronous to clk
//
// How it works
// (R1) data-in reads live synchronised pin levels
// (R2) output latch drives pins set as outputs
// (R3) direction bit one makes pin output
// (R4) function bit one outputs latched address
// (R5) drive bit one on A,B,D,E,G: open drain
// (R6) drive bit one on C,F: fast slew
// (R7) enable status reads live driver enables
// (R8) input cell registers read cell states
// (R9) group A cells loaded by writes, readable
// (R10) group B cells loaded by writes, readable
// (R11) mask A bit one blocks cell load
// (R12) mask B bit one blocks cell load
// (R13) primary sector protection read only
// (R14) secondary protection in bits three..zero
// (R15) bit seven shows security programmed
// (R16) bit zero enables debug port
// (R17) page register resets zero, feeds logic
// (R18) registers at fixed window offsets
// (R19) unused bits zero, read-only writes ignored
`include "pcrb_regs.svh"
module pcrb_top (
    input wire logic clk, // bank clock, 10 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic register_window_select, // host window decode, active high
    input wire logic [7:0] bus_addr, // offset within the window
    input wire logic bus_wr, // write strobe, one cycle
    input wire logic bus_rd, // read strobe, one cycle
    input wire logic [7:0] bus_wdata, // write data
    output logic [7:0] bus_rdata, // read data, registered
    input wire logic [7:0] latched_addr, // latched host address
    input wire logic [6:0][7:0] pin_in, // raw pad levels A..G
    output logic [6:0][7:0] pin_out, // pad output values
    output logic [6:0][7:0] pin_oe, // pad output enables
    output logic [6:0][7:0] pin_slew_fast, // fast slew requests
    output logic [2:0][7:0] input_cell_bits, // input cells A..C
    output logic [7:0] output_cell_group_a_bits, // group A cells
    output logic [7:0] output_cell_group_b_bits, // group B cells
    input wire logic [7:0] primary_protect, // sector protect flags
    input wire logic [3:0] secondary_protect, // sector protect flags
    input wire logic security_set, // security programmed
    output logic debug_port_on, // debug serial port enable
    output logic [7:0] page_bits // page inputs to the logic array
);
    // -----------------------------------------------------------
    // offset tables, one byte per port, port A lowest
    // -----------------------------------------------------------
    localparam pcrb_pkg::pcrb_ports_t DIN_OFS = {`PCRB_DIN_G, `PCRB_DIN_F,
        `PCRB_DIN_E, `PCRB_DIN_D, `PCRB_DIN_C, `PCRB_DIN_B, `PCRB_DIN_A};
    localparam pcrb_pkg::pcrb_ports_t DOUT_OFS = {`PCRB_DOUT_G, `PCRB_DOUT_F,
        `PCRB_DOUT_E, `PCRB_DOUT_D, `PCRB_DOUT_C, `PCRB_DOUT_B, `PCRB_DOUT_A};
    localparam pcrb_pkg::pcrb_ports_t DIR_OFS = {`PCRB_DIR_G, `PCRB_DIR_F,
        `PCRB_DIR_E, `PCRB_DIR_D, `PCRB_DIR_C, `PCRB_DIR_B, `PCRB_DIR_A};
    localparam pcrb_pkg::pcrb_ports_t DRV_OFS = {`PCRB_DRV_G, `PCRB_DRV_F,
        `PCRB_DRV_E, `PCRB_DRV_D, `PCRB_DRV_C, `PCRB_DRV_B, `PCRB_DRV_A};
    localparam pcrb_pkg::pcrb_ports_t CTL_OFS = {`PCRB_CTL_G, `PCRB_CTL_F,
        `PCRB_CTL_E, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam pcrb_pkg::pcrb_ports_t OES_OFS = {8'h00, `PCRB_OES_F,
        8'h00, 8'h00, `PCRB_OES_C, `PCRB_OES_B, `PCRB_OES_A};
    localparam pcrb_pkg::pcrb_ports_t ICL_OFS = {8'h00, 8'h00, 8'h00, 8'h00,
        `PCRB_ICL_C, `PCRB_ICL_B, `PCRB_ICL_A};
    // which ports own which register
    localparam logic [6:0] ALL_PORTS = 7'h7f;
    localparam logic [6:0] CTL_PORTS = 7'h70; // E F G
    localparam logic [6:0] OES_PORTS = 7'h27; // A B C F
    localparam logic [6:0] ICL_PORTS = 7'h07; // A B C
    localparam logic [6:0] OD_PORTS = 7'h5b; // A B D E G
    localparam logic [6:0] SLEW_PORTS = 7'h24; // C F

    // one-hot port hit for a table lookup, used for every per-port register
    function automatic logic [6:0] port_hit(input pcrb_pkg::pcrb_ports_t tbl,
        input logic [6:0] owners, input logic [7:0] a);
        logic [6:0] h;
        h = 7'h00;
        for (int p = 0; p < 7; p++)
        begin
            h[p] = owners[p] && (tbl[p] == a);
        end
        return h;
    endfunction

    // -----------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic [6:0] hit_din;
    logic [6:0] hit_dout;
    logic [6:0] hit_dir;
    logic [6:0] hit_drv;
    logic [6:0] hit_ctl;
    logic [6:0] hit_oes;
    logic [6:0] hit_icl;

    // strobes only count inside the host window
    assign wr_en = register_window_select && bus_wr; // R18
    assign rd_en = register_window_select && bus_rd; // R18
    assign hit_din = port_hit(DIN_OFS, ALL_PORTS, bus_addr);
    assign hit_dout = port_hit(DOUT_OFS, ALL_PORTS, bus_addr);
    assign hit_dir = port_hit(DIR_OFS, ALL_PORTS, bus_addr);
    assign hit_drv = port_hit(DRV_OFS, ALL_PORTS, bus_addr);
    assign hit_ctl = port_hit(CTL_OFS, CTL_PORTS, bus_addr);
    assign hit_oes = port_hit(OES_OFS, OES_PORTS, bus_addr);
    assign hit_icl = port_hit(ICL_OFS, ICL_PORTS, bus_addr);

    // -----------------------------------------------------------
    // port configuration registers
    // -----------------------------------------------------------
    pcrb_pkg::pcrb_ports_t dout_q;
    pcrb_pkg::pcrb_ports_t dir_q;
    pcrb_pkg::pcrb_ports_t drv_q;
    pcrb_pkg::pcrb_ports_t ctl_q;
    pcrb_pkg::pcrb_ports_t level;

    // output latches, direction and driver select for every port
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dout_q <= '0;
            dir_q <= '0; // R3
            drv_q <= '0; // R5 R6
        end
        else
        begin
            for (int p = 0; p < 7; p++)
            begin
                if (wr_en && hit_dout[p])
                    dout_q[p] <= bus_wdata; // R2
                if (wr_en && hit_dir[p])
                    dir_q[p] <= bus_wdata; // R3
                if (wr_en && hit_drv[p])
                    drv_q[p] <= bus_wdata; // R5 R6
            end
        end
    end

    // function select exists on E F G only; other slots stay zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ctl_q <= '0; // R4
        else
        begin
            for (int p = 0; p < 7; p++)
            begin
                if (wr_en && hit_ctl[p])
                    ctl_q[p] <= bus_wdata; // R4
            end
        end
    end

    // -----------------------------------------------------------
    // pin drivers
    // -----------------------------------------------------------
    for (genvar p = 0; p < 7; p++)
    begin : g_port
        pcrb_port #(
            .OD_CAPABLE(OD_PORTS[p]),
            .SLEW_CAPABLE(SLEW_PORTS[p]),
            .ADDR_CAPABLE(CTL_PORTS[p])
        ) u_port (
            .clk(clk),
            .rst_b(rst_b),
            .pin_in(pin_in[p]),
            .out_latch(dout_q[p]),
            .direction(dir_q[p]),
            .drive_sel(drv_q[p]),
            .func_sel(ctl_q[p]),
            .latched_addr(latched_addr),
            .pin_level(level[p]),
            .pin_out(pin_out[p]),
            .pin_oe(pin_oe[p]),
            .slew_fast(pin_slew_fast[p])
        );
    end

    // -----------------------------------------------------------
    // logic cells
    // -----------------------------------------------------------
    logic [7:0] mask_a_q;
    logic [7:0] mask_b_q;
    logic [7:0] cell_a_q;
    logic [7:0] cell_b_q;
    logic [2:0][7:0] icell_q;

    // input cells track the synchronised pins of ports A B C
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            icell_q <= '0;
        else
            icell_q <= level[2:0]; // R8
    end

    // write masks
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mask_a_q <= `PCRB_RST_BYTE; // R11
            mask_b_q <= `PCRB_RST_BYTE; // R12
        end
        else
        begin
            if (wr_en && bus_addr == `PCRB_MASK_A)
                mask_a_q <= bus_wdata;
            if (wr_en && bus_addr == `PCRB_MASK_B)
                mask_b_q <= bus_wdata;
        end
    end

    // a masked bit keeps its old value so software cannot disturb it
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cell_a_q <= `PCRB_RST_BYTE;
            cell_b_q <= `PCRB_RST_BYTE;
        end
        else
        begin
            if (wr_en && bus_addr == `PCRB_OCELL_A)
                cell_a_q <= (cell_a_q & mask_a_q) | (bus_wdata & ~mask_a_q); // R9 R11
            if (wr_en && bus_addr == `PCRB_OCELL_B)
                cell_b_q <= (cell_b_q & mask_b_q) | (bus_wdata & ~mask_b_q); // R10 R12
        end
    end

    assign input_cell_bits = icell_q;
    assign output_cell_group_a_bits = cell_a_q;
    assign output_cell_group_b_bits = cell_b_q;

    // -----------------------------------------------------------
    // debug port and page
    // -----------------------------------------------------------
    logic dbg_q;
    logic [7:0] page_q;

    // only bit zero of the debug register is kept
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dbg_q <= 1'b0;
            page_q <= `PCRB_RST_BYTE; // R17
        end
        else
        begin
            if (wr_en && bus_addr == `PCRB_DBG_EN)
                dbg_q <= bus_wdata[`PCRB_DBG_ON_BIT]; // R16
            if (wr_en && bus_addr == `PCRB_PAGE)
                page_q <= bus_wdata; // R17
        end
    end

    assign debug_port_on = dbg_q; // R16
    assign page_bits = page_q; // R17

    // -----------------------------------------------------------
    // read path
    // -----------------------------------------------------------
    logic [7:0] rd_val;

    // offsets are distinct, so at most one source matches
    always_comb
    begin
        rd_val = 8'h00; // R19
        for (int p = 0; p < 7; p++)
        begin
            if (hit_din[p])
                rd_val = level[p]; // R1
            if (hit_dout[p])
                rd_val = dout_q[p];
            if (hit_dir[p])
                rd_val = dir_q[p];
            if (hit_drv[p])
                rd_val = drv_q[p];
            if (hit_ctl[p])
                rd_val = ctl_q[p];
            if (hit_oes[p])
                rd_val = pin_oe[p]; // R7
            if (hit_icl[p])
                rd_val = icell_q[p]; // R8
        end
        unique case (bus_addr)
            `PCRB_OCELL_A: rd_val = cell_a_q; // R9
            `PCRB_OCELL_B: rd_val = cell_b_q; // R10
            `PCRB_MASK_A: rd_val = mask_a_q;
            `PCRB_MASK_B: rd_val = mask_b_q;
            `PCRB_PROT_PRI: rd_val = primary_protect; // R13
            `PCRB_PROT_SEC: rd_val = {security_set, 3'h0, secondary_protect}; // R14 R15
            `PCRB_DBG_EN: rd_val = {7'h00, dbg_q}; // R19
            `PCRB_PAGE: rd_val = page_q;
            default: ;
        endcase
    end

    // read data is held until the next read
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            bus_rdata <= `PCRB_RST_BYTE;
        else if (rd_en)
            bus_rdata <= rd_val; // R18
    end

    // -----------------------------------------------------------
    // assertions
    // -----------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    din_read_a: assert property (rd_en && bus_addr == `PCRB_DIN_A |=> // R1
        bus_rdata == $past(level[0])) else $error("data-in read wrong");
    dout_pin_a: assert property (wr_en && bus_addr == `PCRB_DOUT_D // R2
        && dir_q[3] == 8'hff && drv_q[3] == 8'h00 && !(wr_en && hit_dir[3]) |=>
        pin_out[3] == $past(bus_wdata) && pin_oe[3] == 8'hff) else $error("latch not on pins");
    dir_input_a: assert property ((dir_q[0] | ctl_q[0]) == 8'h00 |-> // R3
        pin_oe[0] == 8'h00) else $error("input pin driven");
    addr_out_a: assert property (ctl_q[4][0] && !drv_q[4][0] |-> // R4
        pin_oe[4][0] && pin_out[4][0] == latched_addr[0])
        else $error("address out wrong");
    open_drain_a: assert property (drv_q[1][7] && dout_q[1][7] |-> // R5
        !pin_oe[1][7] && !pin_out[1][7]) else $error("open drain drives high");
    slew_sel_a: assert property (pin_slew_fast[2] == drv_q[2] // R6
        && pin_slew_fast[0] == 8'h00) else $error("slew select wrong");
    oe_status_a: assert property (rd_en && bus_addr == `PCRB_OES_F |=> // R7
        bus_rdata == $past(pin_oe[5])) else $error("enable status wrong");
    cell_mask_a: assert property (wr_en && bus_addr == `PCRB_OCELL_A |=> // R11
        ((cell_a_q ^ $past(cell_a_q)) & $past(mask_a_q)) == 8'h00
        && (cell_a_q & ~$past(mask_a_q)) == ($past(bus_wdata) & ~$past(mask_a_q)))
        else $error("mask A not honoured");
    sec_read_a: assert property (rd_en && bus_addr == `PCRB_PROT_SEC |=> // R15
        bus_rdata[`PCRB_SEC_SECURITY_BIT] == $past(security_set)
        && bus_rdata[6:4] == 3'h0) else $error("secondary protect read wrong");
    page_load_a: assert property (wr_en && bus_addr == `PCRB_PAGE |=> // R17
        page_bits == $past(bus_wdata)
        ##1 ($past(wr_en && bus_addr == `PCRB_PAGE) || $stable(page_bits)))
        else $error("page not loaded");
    unmapped_zero_a: assert property (rd_en && bus_addr == 8'hff |=> // R19
        bus_rdata == 8'h00) else $error("unmapped read not zero");

    wr_dout_c: cover property (wr_en && hit_dout != 7'h00);
    rd_din_c: cover property (rd_en && hit_din != 7'h00);
    masked_cell_c: cover property (wr_en && bus_addr == `PCRB_OCELL_B && mask_b_q != 8'h00);
    debug_on_c: cover property (!debug_port_on ##1 debug_port_on);
endmodule // pcrb_top

/* pcrb_host_model.sv */
// host side of the bank: an 8-bit controller moving byte reads and writes
// assumes: the bank takes strobes at posedge clk; this model moves at negedge
module pcrb_host_model (
    input wire logic clk, // bank clock
    output logic sel, // window select, active high
    output logic [7:0] addr, // offset in the window
    output logic wr, // write strobe
    output logic rd, // read strobe
    output logic [7:0] wdata, // write data
    input wire logic [7:0] rdata // registered read data
);
    // --------------------------------
    // idle bus
    // --------------------------------
    // strobes low from time zero
    initial
    begin
        sel = 1'b0;
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end

    // released lines flip, so a stale address or byte can never look valid
    function automatic void release_bus();
        sel = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = ~addr;
        wdata = ~wdata;
    endfunction

    // --------------------------------
    // transfers
    // --------------------------------
    // one-cycle write; s low gives a strobe the window decode must ignore
    task automatic write(input logic [7:0] a, input logic [7:0] d, input logic s);
        @(negedge clk);
        sel = s;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        release_bus();
    endtask

    // one-cycle read; data is registered at the taking edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sel = 1'b1;
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        d = rdata;
        release_bus();
    endtask
endmodule // pcrb_host_model

/* port_and_cell_register_bank_tb.sv */
// self-checking bench for the port and cell register bank
// assumes: design files and pcrb_host_model compiled first; pads driven here
`include "pcrb_regs.svh"
module port_and_cell_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b;
    logic sel, wr, rd, security_set, debug_port_on;
    logic [7:0] addr, wdata, rdata, latched_addr, primary_protect, page_bits, cell_a, cell_b;
    logic [6:0][7:0] pin_in, pin_out, pin_oe, pin_slew_fast;
    logic [2:0][7:0] input_cell_bits;
    logic [3:0] secondary_protect;
    int failures = 0;
    int n_compared = 0;
    logic [7:0] din_off [7] = '{`PCRB_DIN_A, `PCRB_DIN_B, `PCRB_DIN_C, `PCRB_DIN_D,
        `PCRB_DIN_E, `PCRB_DIN_F, `PCRB_DIN_G};
    logic [7:0] dout_off [7] = '{`PCRB_DOUT_A, `PCRB_DOUT_B, `PCRB_DOUT_C, `PCRB_DOUT_D,
        `PCRB_DOUT_E, `PCRB_DOUT_F, `PCRB_DOUT_G};
    logic [7:0] dir_off [7] = '{`PCRB_DIR_A, `PCRB_DIR_B, `PCRB_DIR_C, `PCRB_DIR_D,
        `PCRB_DIR_E, `PCRB_DIR_F, `PCRB_DIR_G};
    logic [7:0] icl_off [3] = '{`PCRB_ICL_A, `PCRB_ICL_B, `PCRB_ICL_C};

    // 10 MHz bank clock
    always #50 clk = ~clk;

    pcrb_top dut (.clk(clk), .rst_b(rst_b), .register_window_select(sel), .bus_addr(addr),
        .bus_wr(wr), .bus_rd(rd), .bus_wdata(wdata), .bus_rdata(rdata),
        .latched_addr(latched_addr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_slew_fast(pin_slew_fast), .input_cell_bits(input_cell_bits),
        .output_cell_group_a_bits(cell_a), .output_cell_group_b_bits(cell_b),
        .primary_protect(primary_protect), .secondary_protect(secondary_protect),
        .security_set(security_set), .debug_port_on(debug_port_on), .page_bits(page_bits));

    pcrb_host_model host (.clk(clk), .sel(sel), .addr(addr), .wr(wr), .rd(rd),
        .wdata(wdata), .rdata(rdata));

    // --------------------------------
    // helpers
    // --------------------------------
    task automatic cmp8(input logic [7:0] got_v, input logic [7:0] exp_v);
        n_compared++;
        if (got_v !== exp_v)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.read(a, v);
        cmp8(v, e);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        host.write(a, d, 1'b1);
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // distinct pad pattern per port, so a swapped port index shows up
    function automatic logic [7:0] pat(input int p);
        return 8'h3c + 8'(p) * 8'h11;
    endfunction

    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        rst_b = 1'b0;
        latched_addr = 8'hc3;
        for (int p = 0; p < 7; p++)
            pin_in[p] = pat(p);
        primary_protect = 8'h96;
        secondary_protect = 4'h9;
        security_set = 1'b1;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        // defaults, pad readback and input cells
        for (int p = 0; p < 7; p++)
        begin
            cmp8(pin_oe[p], 8'h00);
            rd_chk(dir_off[p], 8'h00);
            rd_chk(din_off[p], pat(p));
        end
        for (int c = 0; c < 3; c++)
        begin
            rd_chk(icl_off[c], pat(c));
            cmp8(input_cell_bits[c], pat(c));
        end
        rd_chk(`PCRB_OES_A, 8'h00);
        rd_chk(`PCRB_MASK_A, 8'h00);
        rd_chk(`PCRB_MASK_B, 8'h00);
        rd_chk(`PCRB_PAGE, 8'h00);
        cmp8(page_bits, 8'h00);
        cmp8({7'h00, debug_port_on}, 8'h00);
        // every port as a full output: the latch must reach the pad
        for (int p = 0; p < 7; p++)
        begin
            wr_reg(dout_off[p], ~pat(p));
            wr_reg(dir_off[p], 8'hff);
            cmp8(pin_oe[p], 8'hff);
            cmp8(pin_out[p], ~pat(p));
            rd_chk(dout_off[p], ~pat(p));
        end
        rd_chk(`PCRB_OES_F, 8'hff);
        wr_reg(`PCRB_DOUT_D, 8'h5a);
        cmp8(pin_out[3], 8'h5a);
        wr_reg(`PCRB_DIR_A, 8'h0f);
        cmp8(pin_oe[0], 8'h0f);
        rd_chk(`PCRB_OES_A, 8'h0f);
        // open drain on the upper half of B: a high bit releases the pad
        wr_reg(`PCRB_DOUT_B, 8'haa);
        wr_reg(`PCRB_DRV_B, 8'hf0);
        cmp8(pin_oe[1], 8'h5f);
        cmp8(pin_out[1], 8'h0a);
        cmp8(pin_slew_fast[1], 8'h00);
        rd_chk(`PCRB_OES_B, 8'h5f);
        // on C the same select means fast slew, still push-pull
        wr_reg(`PCRB_DRV_C, 8'h3c);
        cmp8(pin_slew_fast[2], 8'h3c);
        cmp8(pin_oe[2], 8'hff);
        cmp8(pin_out[2], ~pat(2));
        rd_chk(`PCRB_DRV_C, 8'h3c);
        // address out on the low half of E while its pins are inputs
        wr_reg(`PCRB_DIR_E, 8'h00);
        wr_reg(`PCRB_CTL_E, 8'h0f);
        cmp8(pin_oe[4], 8'h0f);
        cmp8(pin_out[4] & 8'h0f, 8'h03);
        // output cells, then masked loads keep the blocked bits
        wr_reg(`PCRB_OCELL_A, 8'ha5);
        rd_chk(`PCRB_OCELL_A, 8'ha5);
        wr_reg(`PCRB_MASK_A, 8'h0f);
        wr_reg(`PCRB_OCELL_A, 8'h5a);
        rd_chk(`PCRB_OCELL_A, 8'h55);
        cmp8(cell_a, 8'h55);
        wr_reg(`PCRB_OCELL_B, 8'h3c);
        wr_reg(`PCRB_MASK_B, 8'hf0);
        wr_reg(`PCRB_OCELL_B, 8'hc3);
        rd_chk(`PCRB_OCELL_B, 8'h33);
        cmp8(cell_b, 8'h33);
        rd_chk(`PCRB_MASK_B, 8'hf0);
        // protection status is read only
        wr_reg(`PCRB_PROT_PRI, 8'h00);
        rd_chk(`PCRB_PROT_PRI, 8'h96);
        rd_chk(`PCRB_PROT_SEC, 8'h89);
        security_set = 1'b0;
        secondary_protect = 4'h6;
        rd_chk(`PCRB_PROT_SEC, 8'h06);
        // debug port: only bit zero is stored
        wr_reg(`PCRB_DBG_EN, 8'hff);
        cmp8({7'h00, debug_port_on}, 8'h01);
        rd_chk(`PCRB_DBG_EN, 8'h01);
        wr_reg(`PCRB_DBG_EN, 8'hfe);
        cmp8({7'h00, debug_port_on}, 8'h00);
        // page, then a strobe without the window select
        wr_reg(`PCRB_PAGE, 8'h7e);
        host.write(`PCRB_PAGE, 8'h11, 1'b0);
        cmp8(page_bits, 8'h7e);
        rd_chk(`PCRB_PAGE, 8'h7e);
        // unmapped offset and a write to pad readback
        wr_reg(8'h02, 8'hff);
        rd_chk(8'h02, 8'h00);
        wr_reg(`PCRB_DIN_A, 8'h00);
        rd_chk(`PCRB_DIN_A, pat(0));
        // reset in mid-run clears page, pads and cells
        rst_b = 1'b0;
        @(negedge clk);
        cmp8(page_bits, 8'h00);
        cmp8(pin_oe[1], 8'h00);
        rst_b = 1'b1;
        rd_chk(`PCRB_OCELL_A, 8'h00);
        report_and_stop();
    end

    // hang guard: far beyond the length of the main sequence
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule // port_and_cell_register_bank_tb
